// ==== shared/ars_defines.svh ====
/*
  sizes, field positions, reset values and step codes of the request sequencer.
  assumes: included by its bare name, after the package, by every design file.
*/
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH
`define ARS_RES_N 8
`define ARS_BANK_N 16
`define ARS_RES_W 10
`define ARS_ACC_W 13
`define ARS_ACC_LAST 2'h3
`define ARS_QD 4
`define ARS_CH_N 24
`define ARS_PIN_N 20
`define ARS_TRIG_N 4
`define ARS_CH1_BASE 5'h10
`define ARS_DIV_MIN 6'h03
`define ARS_SAMP_MIN 8'h01
`define ARS_STEP_TOP 10'h200
`define ARS_STEP_END10 10'h001
`define ARS_STEP_END8 10'h004
`define ARS_EMUX_RST 3'h0
`endif

// ==== shared/ars_pkg.sv ====
/*
  types of the request sequencer: converter step states and request sources.
  assumes: compiled before every design file.
*/
package ars_pkg;
  typedef enum logic [2:0] {
    ARS_SAR_IDLE = 3'b001,
    ARS_SAR_SAMP = 3'b010,
    ARS_SAR_CONV = 3'b100
  } ars_sar_st_t;
  typedef enum logic [3:0] {
    ARS_SRC_NONE = 4'b0001,
    ARS_SRC_INS = 4'b0010,
    ARS_SRC_QUE = 4'b0100,
    ARS_SRC_PAR = 4'b1000
  } ars_src_t;
endpackage

// ==== hdl/ars_sar.sv ====
/*
  one successive-approximation step engine: sample phase, then one bit per step.
  assumes: cmp_hi is already synchronised; it is high while input >= dac_code.
*/
`timescale 1ns/1ps
`include "ars_defines.svh"
module ars_sar
  import ars_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic res8,
  input wire logic [7:0] samp_time,
  input wire logic [5:0] conv_div,
  input wire logic cmp_hi,
  output logic busy,
  output logic sampling,
  output logic [9:0] dac_code,
  output logic [9:0] result,
  output logic done
);
  ars_sar_st_t st_r;
  ars_sar_st_t st_nxt;
  logic [5:0] div_r;
  logic [7:0] scnt_r;
  logic [9:0] step_r;
  logic [9:0] dac_r;
  logic [9:0] res_r;
  logic done_r;
  logic tick;
  logic last_step;
  logic [5:0] div_load;
  logic [7:0] samp_end;
  logic [9:0] code_kept;

  // step clock floor keeps room for the comparator synchroniser
  assign div_load = (conv_div < `ARS_DIV_MIN) ? `ARS_DIV_MIN : conv_div;
  assign samp_end = (samp_time < `ARS_SAMP_MIN) ? `ARS_SAMP_MIN : samp_time;
  assign busy = st_r != ARS_SAR_IDLE;
  assign sampling = st_r == ARS_SAR_SAMP;
  assign tick = busy && (div_r == 6'h00);
  assign last_step = step_r == (res8 ? `ARS_STEP_END8 : `ARS_STEP_END10);
  assign code_kept = cmp_hi ? dac_r : (dac_r & ~step_r);
  assign dac_code = dac_r;
  assign result = res_r;
  assign done = done_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ARS_SAR_IDLE: if (start) st_nxt = ARS_SAR_SAMP;
      ARS_SAR_SAMP: if (tick && scnt_r == samp_end) st_nxt = ARS_SAR_CONV;
      ARS_SAR_CONV: if (tick && last_step) st_nxt = ARS_SAR_IDLE;
      default: st_nxt = ARS_SAR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ARS_SAR_IDLE;
      div_r <= 6'h00;
      scnt_r <= 8'h01;
      step_r <= 10'h000;
      dac_r <= 10'h000;
      res_r <= 10'h000;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      done_r <= 1'b0;
      if (!busy || tick) begin
        div_r <= div_load;
      end else begin
        div_r <= div_r - 6'h01;
      end
      if (!busy) begin
        scnt_r <= 8'h01;
      end else if (sampling && tick) begin
        scnt_r <= scnt_r + 8'h01;
        if (scnt_r == samp_end) begin
          step_r <= `ARS_STEP_TOP;
          dac_r <= `ARS_STEP_TOP;
        end
      end
      if (st_r == ARS_SAR_CONV && tick) begin
        if (last_step) begin
          res_r <= res8 ? {2'b00, code_kept[9:2]} : code_kept;
          done_r <= 1'b1;
        end else begin
          step_r <= step_r >> 1;
          dac_r <= code_kept | (step_r >> 1);
        end
      end
    end
  end
endmodule

// ==== hdl/adc_request_sequencer.sv ====
/*
  request sources, arbiter, two converter engines and their result banks.
  assumes: config inputs come from same-clock logic; cmp_in, trig_ext and
  pin_in are asynchronous; the analog stage follows dac codes and selects.
*/
`timescale 1ns/1ps
`include "ars_defines.svh"
// How it works
// - each converter resolves one result bit per approximation step
// - results are 10 bits, or 8 bits with fewer steps
// - converters serve 16 and 8 inputs, four pins shared by both
// - sample time and step time are programmable
// - parallel source marks many channels, converts lowest channel first
// - queued source converts entries in the order they were written
// - parallel and queued sources start from internal, external or software triggers
// - arbiter grants the converter by programmed priority level
// - single inserted channel runs between sequence steps without losing any
// - eight result registers per converter, optionally chained as a FIFO
// - wait-for-read keeps unread results from being overwritten
// - results may be limit checked or accumulated
// - selected result registers raise a result event
// - both converters can sample two channels at the same moment
// - external multiplexer select advances automatically
// - per-pin digital input disable; unused pins stay digital inputs
// - analog part is powered down while no conversion runs
// - broken-wire precharge per channel and a multiplexer test mode
module adc_request_sequencer
  import ars_pkg::*;
#(
  parameter int QD = `ARS_QD
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`ARS_TRIG_N-1:0] trig_ext,
  input wire logic [`ARS_TRIG_N-1:0] trig_int,
  input wire logic [`ARS_CH_N-1:0] par_mask,
  input wire logic par_trig_en,
  input wire logic [2:0] par_trig_sel,
  input wire logic sw_par_trig,
  input wire logic [1:0] par_prio,
  input wire logic [2:0] par_rsel,
  input wire logic q_wr_valid,
  input wire logic [4:0] q_wr_chan,
  input wire logic [2:0] q_wr_rsel,
  output logic q_wr_ready,
  input wire logic q_trig_en,
  input wire logic [2:0] q_trig_sel,
  input wire logic sw_q_trig,
  input wire logic [1:0] q_prio,
  input wire logic ins_req,
  input wire logic [4:0] ins_chan,
  input wire logic [2:0] ins_rsel,
  input wire logic [1:0] ins_prio,
  output logic ins_busy,
  input wire logic sync_en,
  input wire logic [2:0] sync_chan1,
  input wire logic res8,
  input wire logic [7:0] samp_time,
  input wire logic [5:0] conv_div,
  input wire logic [1:0] cmp_in,
  output logic [1:0] sh_sample,
  output logic [9:0] dac_code0,
  output logic [9:0] dac_code1,
  output logic [1:0] ana_pd,
  output logic [3:0] amux0_sel,
  output logic [2:0] amux1_sel,
  input wire logic emux_en,
  input wire logic [4:0] emux_chan,
  input wire logic [2:0] emux_last,
  output logic [2:0] ext_mux_sel,
  input wire logic [`ARS_CH_N-1:0] bwd_en,
  output logic [1:0] bwd_pre,
  input wire logic mux_test,
  output logic [1:0] mux_test_on,
  input wire logic [`ARS_PIN_N-1:0] pin_in,
  input wire logic [`ARS_PIN_N-1:0] dig_in_dis,
  output logic [`ARS_PIN_N-1:0] dig_in,
  input wire logic [`ARS_BANK_N-1:0] wfr_en,
  input wire logic [`ARS_BANK_N-1:0] chain_en,
  input wire logic [`ARS_BANK_N-1:0] acc_en,
  input wire logic [`ARS_BANK_N-1:0] lim_en,
  input wire logic [`ARS_BANK_N-1:0] irq_sel,
  input wire logic [9:0] lim_lo,
  input wire logic [9:0] lim_hi,
  input wire logic rd_strobe,
  input wire logic rd_conv,
  input wire logic [2:0] rd_idx,
  output logic [`ARS_ACC_W-1:0] rd_data,
  output logic rd_valid,
  output logic [1:0] res_evt,
  output logic [`ARS_CH_N-1:0] par_pend,
  output logic conv_busy
);
  localparam int QW = $clog2(QD);
  localparam logic [QW:0] Q_FULL = (QW+1)'(QD);

  // ************************************************************
  // functions
  // ************************************************************
  // lowest pending channel wins, giving a fixed order
  function automatic logic [4:0] ars_first(input logic [`ARS_CH_N-1:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = `ARS_CH_N - 1; i >= 0; i--) begin
      if (m[i]) r = 5'(i);
    end
    return r;
  endfunction

  // target register full under wait-for-read, also the mirror in sync mode
  function automatic logic ars_hold(input logic [4:0] ch, input logic [2:0] rs,
                                    input logic [`ARS_BANK_N-1:0] h, input logic sy);
    logic c1;
    c1 = ch >= `ARS_CH1_BASE;
    return h[{c1, rs}] || (sy && !c1 && h[{1'b1, rs}]);
  endfunction

  // ************************************************************
  // input synchronisers and triggers
  // ************************************************************
  logic [1:0] cmp_s1_r, cmp_s2_r;
  logic [`ARS_TRIG_N-1:0] trg_s1_r, trg_s2_r, trg_s3_r;
  logic [`ARS_PIN_N-1:0] pin_s1_r, pin_s2_r, dig_r;
  logic [7:0] trig_vec;
  logic par_go, q_go;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_r <= 2'h0;
      cmp_s2_r <= 2'h0;
      trg_s1_r <= '0;
      trg_s2_r <= '0;
      trg_s3_r <= '0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      dig_r <= '0;
    end else begin
      cmp_s1_r <= cmp_in;
      cmp_s2_r <= cmp_s1_r;
      trg_s1_r <= trig_ext;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      dig_r <= pin_s2_r & ~dig_in_dis;
    end
  end

  assign trig_vec = {trig_int, trg_s2_r & ~trg_s3_r};
  assign par_go = sw_par_trig || (par_trig_en && trig_vec[par_trig_sel]);
  assign q_go = sw_q_trig || (q_trig_en && trig_vec[q_trig_sel]);

  // ************************************************************
  // request sources and arbiter
  // ************************************************************
  ars_src_t src_r;
  logic [4:0] cur_chan_r;
  logic [2:0] cur_rsel_r;
  logic cur_c1_r;
  logic [`ARS_CH_N-1:0] pend_r;
  logic [QD-1:0][7:0] q_mem_r;
  logic [QW-1:0] q_wp_r, q_rp_r;
  logic [QW:0] q_cnt_r;
  logic q_run_r;
  logic ins_pend_r;
  logic [4:0] ins_chan_r;
  logic [2:0] ins_rsel_r;
  logic [3:0] amux0_r;
  logic [2:0] amux1_r;
  logic [1:0] bwd_r;
  logic [2:0] emux_r;
  logic [`ARS_BANK_N-1:0] val_r, val_nxt;
  logic [`ARS_BANK_N-1:0] hold_v;
  logic [7:0] q_head;
  logic [4:0] par_ch, gnt_chan;
  logic [2:0] gnt_rsel;
  logic ins_ok, q_ok, par_ok, win_ins, win_q, win_par, grant, gnt_c1;
  logic q_push, q_pop, lead_done, idle;
  logic [1:0] start, done, busy;

  assign idle = src_r == ARS_SRC_NONE;
  assign q_head = q_mem_r[q_rp_r];
  assign par_ch = ars_first(pend_r);
  assign hold_v = wfr_en & val_r;
  assign ins_ok = ins_pend_r && !ars_hold(ins_chan_r, ins_rsel_r, hold_v, sync_en);
  assign q_ok = q_run_r && (q_cnt_r != '0) && !ars_hold(q_head[4:0], q_head[7:5], hold_v, sync_en);
  assign par_ok = (pend_r != '0) && !ars_hold(par_ch, par_rsel, hold_v, sync_en);
  // priority, ties go insert, queue, parallel
  assign win_ins = ins_ok && (!q_ok || ins_prio >= q_prio) && (!par_ok || ins_prio >= par_prio);
  assign win_q = q_ok && !win_ins && (!par_ok || q_prio >= par_prio);
  assign win_par = par_ok && !win_ins && !win_q;
  assign grant = idle && (win_ins || win_q || win_par);
  assign gnt_chan = win_ins ? ins_chan_r : (win_q ? q_head[4:0] : par_ch);
  assign gnt_rsel = win_ins ? ins_rsel_r : (win_q ? q_head[7:5] : par_rsel);
  assign gnt_c1 = gnt_chan >= `ARS_CH1_BASE;
  assign start[0] = grant && !gnt_c1;
  assign start[1] = grant && (gnt_c1 || sync_en);
  assign lead_done = cur_c1_r ? done[1] : done[0];
  assign q_push = q_wr_valid && q_wr_ready;
  assign q_pop = lead_done && src_r == ARS_SRC_QUE;
  assign q_wr_ready = q_cnt_r != Q_FULL;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= ARS_SRC_NONE;
      cur_chan_r <= 5'h00;
      cur_rsel_r <= 3'h0;
      cur_c1_r <= 1'b0;
      amux0_r <= 4'h0;
      amux1_r <= 3'h0;
      bwd_r <= 2'h0;
    end else if (grant) begin
      src_r <= win_ins ? ARS_SRC_INS : (win_q ? ARS_SRC_QUE : ARS_SRC_PAR);
      cur_chan_r <= gnt_chan;
      cur_rsel_r <= gnt_rsel;
      cur_c1_r <= gnt_c1;
      amux0_r <= gnt_chan[3:0];
      amux1_r <= gnt_c1 ? gnt_chan[2:0] : sync_chan1;
      bwd_r[0] <= bwd_en[gnt_chan];
      bwd_r[1] <= gnt_c1 ? bwd_en[gnt_chan] : bwd_en[{2'b10, sync_chan1}];
    end else if (lead_done) begin
      src_r <= ARS_SRC_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      ins_pend_r <= 1'b0;
      ins_chan_r <= 5'h00;
      ins_rsel_r <= 3'h0;
      q_run_r <= 1'b0;
      emux_r <= `ARS_EMUX_RST;
    end else begin
      // set wins over the clear of the finished channel
      pend_r <= (pend_r & ~((lead_done && src_r == ARS_SRC_PAR) ?
                 (`ARS_CH_N'(1) << cur_chan_r) : '0)) | (par_go ? par_mask : '0);
      // insert leaves the sequence state untouched
      if (ins_req && !ins_pend_r) begin
        ins_pend_r <= 1'b1;
        ins_chan_r <= ins_chan;
        ins_rsel_r <= ins_rsel;
      end else if (lead_done && src_r == ARS_SRC_INS) begin
        ins_pend_r <= 1'b0;
      end
      if (q_go) begin
        q_run_r <= 1'b1;
      end else if (q_cnt_r == '0) begin
        q_run_r <= 1'b0;
      end
      // external multiplexer steps after each of its conversions
      if (lead_done && emux_en && cur_chan_r == emux_chan) begin
        emux_r <= (emux_r == emux_last) ? `ARS_EMUX_RST : emux_r + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_mem_r <= '0;
      q_wp_r <= '0;
      q_rp_r <= '0;
      q_cnt_r <= '0;
    end else begin
      if (q_push) begin
        q_mem_r[q_wp_r] <= {q_wr_rsel, q_wr_chan};
        q_wp_r <= q_wp_r + 1'b1;
      end
      if (q_pop) begin
        q_rp_r <= q_rp_r + 1'b1;
      end
      q_cnt_r <= q_cnt_r + (QW+1)'(q_push) - (QW+1)'(q_pop);
    end
  end

  // ************************************************************
  // converter engines
  // ************************************************************
  logic [1:0][9:0] dac_w, res_w;
  logic [1:0][`ARS_ACC_W-1:0] res_d;
  logic [1:0][3:0] wr_idx;
  logic [1:0] keep;

  for (genvar c = 0; c < 2; c++) begin : g_conv
    ars_sar u_sar (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(start[c]),
      .res8(res8),
      .samp_time(samp_time),
      .conv_div(conv_div),
      .cmp_hi(cmp_s2_r[c]),
      .busy(busy[c]),
      .sampling(sh_sample[c]),
      .dac_code(dac_w[c]),
      .result(res_w[c]),
      .done(done[c])
    );
    assign res_d[c] = {3'b000, res_w[c]};
    assign wr_idx[c] = {1'(c), cur_rsel_r};
    // limit check stores only results outside the band
    assign keep[c] = !lim_en[wr_idx[c]] || (res_w[c] < lim_lo) || (res_w[c] > lim_hi);
    assign ana_pd[c] = !busy[c];
    assign bwd_pre[c] = sh_sample[c] && bwd_r[c];
    assign mux_test_on[c] = sh_sample[c] && mux_test;
  end

  // ************************************************************
  // result banks
  // ************************************************************
  logic [`ARS_BANK_N-1:0][`ARS_ACC_W-1:0] dat_r, dat_nxt;
  logic [`ARS_BANK_N-1:0][1:0] acnt_r, acnt_nxt;
  logic [1:0] evt_r, evt_nxt;
  logic [`ARS_ACC_W-1:0] rd_data_r;
  logic rd_valid_r;
  logic [3:0] rd_sel;

  assign rd_sel = {rd_conv, rd_idx};

  // eight registers per converter with optional chaining
  always_comb begin
    logic [3:0] wi;
    wi = 4'h0;
    val_nxt = val_r;
    dat_nxt = dat_r;
    acnt_nxt = acnt_r;
    evt_nxt = 2'b00;
    if (rd_strobe) val_nxt[rd_sel] = 1'b0;
    for (int i = 1; i < `ARS_BANK_N; i++) begin
      if ((i % `ARS_RES_N) != 0 && chain_en[i] && val_r[i] && !val_r[i-1]) begin
        dat_nxt[i-1] = dat_r[i];
        val_nxt[i-1] = 1'b1;
        val_nxt[i] = 1'b0;
      end
    end
    for (int c = 0; c < 2; c++) begin
      wi = wr_idx[c];
      if (done[c] && keep[c]) begin
        if (acc_en[wi]) begin
          dat_nxt[wi] = (acnt_r[wi] == 2'h0) ? res_d[c] : dat_r[wi] + res_d[c];
          acnt_nxt[wi] = acnt_r[wi] + 2'h1;
        end else begin
          dat_nxt[wi] = res_d[c];
        end
        // register turns valid only without accumulation or on its last accumulated result
        if (!acc_en[wi] || acnt_r[wi] == `ARS_ACC_LAST) begin
          val_nxt[wi] = 1'b1;
          evt_nxt[c] = irq_sel[wi];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      val_r <= '0;
      dat_r <= '0;
      acnt_r <= '0;
      evt_r <= 2'b00;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      val_r <= val_nxt;
      dat_r <= dat_nxt;
      acnt_r <= acnt_nxt;
      evt_r <= evt_nxt;
      if (rd_strobe) begin
        rd_data_r <= dat_r[rd_sel];
        rd_valid_r <= val_r[rd_sel];
      end
    end
  end

  assign dac_code0 = dac_w[0];
  assign dac_code1 = dac_w[1];
  assign amux0_sel = amux0_r;
  assign amux1_sel = amux1_r;
  assign ext_mux_sel = emux_r;
  assign dig_in = dig_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign res_evt = evt_r;
  assign par_pend = pend_r;
  assign ins_busy = ins_pend_r;
  assign conv_busy = !idle;
endmodule

// ==== test/ars_ana_model.sv ====
/*
  analog stage model: input voltages per select, comparator per converter.
  assumes: selects and trial codes come straight from the sequencer.
*/
`timescale 1ns/1ps
module ars_ana_model (
  input wire logic [3:0] amux0_sel,
  input wire logic [2:0] amux1_sel,
  input wire logic [9:0] dac_code0,
  input wire logic [9:0] dac_code1,
  output logic [1:0] cmp_in
);
  logic [9:0] vin0;
  logic [9:0] vin1;
  // comparator high while the held input is at or above the trial code
  assign vin0 = 10'(amux0_sel) * 10'h028 + 10'h011;
  assign vin1 = 10'(amux1_sel) * 10'h01E + 10'h2BC;
  assign cmp_in = {vin1 >= dac_code1, vin0 >= dac_code0};
endmodule

// ==== test/ars_properties.sv ====
/*
  concurrent checks on the sequencer ports.
  assumes: bound into adc_request_sequencer, one clock domain.
*/
`timescale 1ns/1ps
module ars_properties #(
  parameter int QD = 4
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ins_req,
  input wire logic ins_busy,
  input wire logic q_wr_valid,
  input wire logic q_wr_ready,
  input wire logic rd_strobe,
  input wire logic rd_valid,
  input wire logic [7:0] samp_time,
  input wire logic [5:0] conv_div,
  input wire logic [1:0] sh_sample,
  input wire logic [1:0] ana_pd,
  input wire logic conv_busy,
  input wire logic [9:0] dac_code0,
  input wire logic [1:0] bwd_pre,
  input wire logic [1:0] mux_test_on,
  input wire logic [19:0] dig_in,
  input wire logic [19:0] dig_in_dis,
  input wire logic [2:0] ext_mux_sel,
  input wire logic [1:0] res_evt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence samp_start_s;
    $rose(sh_sample[0]) && samp_time == 8'h01 && conv_div == 6'h03;
  endsequence
  sequence samp_hold_s;
    sh_sample[0] [*3] ##[1:3] !sh_sample[0];
  endsequence
  AST_SAMP_LEN: assert property (samp_start_s |-> samp_hold_s)
    else $error("sample phase length off");
  AST_FIRST_TRIAL: assert property (samp_start_s |-> ##[0:6] dac_code0 == 10'h200)
    else $error("first trial code is not the top bit");
  AST_PD_SAMPLE: assert property (sh_sample[0] |-> !ana_pd[0] && conv_busy)
    else $error("analog part down while sampling");
  AST_EVT_PULSE: assert property (res_evt[0] |=> !res_evt[0])
    else $error("result event longer than one cycle");
  AST_INS_TAKE: assert property (ins_req && !ins_busy |=> ins_busy)
    else $error("insert request not taken");
  AST_RD_CAUSE: assert property ($rose(rd_valid) |-> $past(rd_strobe))
    else $error("read valid rose without a read");
  AST_Q_FULL: assert property ($fell(q_wr_ready) |-> $past(q_wr_valid))
    else $error("queue filled without a write");
  AST_AUX_SAMPLE: assert property (bwd_pre[0] || mux_test_on[0] |-> sh_sample[0])
    else $error("test aid active outside sampling");
  AST_DIG_DIS: assert property ((dig_in & $past(dig_in_dis)) == 20'h00000)
    else $error("disabled pin passes to digital input");
  AST_EMUX_STEP: assert property ($changed(ext_mux_sel) |->
    ext_mux_sel == 3'h0 || ext_mux_sel == $past(ext_mux_sel) + 3'h1)
    else $error("external select skipped");
endmodule
bind adc_request_sequencer ars_properties #(.QD(QD)) ars_properties_inst (
  .core_clk(core_clk), .rst_n(rst_n), .ins_req(ins_req), .ins_busy(ins_busy),
  .q_wr_valid(q_wr_valid), .q_wr_ready(q_wr_ready), .rd_strobe(rd_strobe),
  .rd_valid(rd_valid), .samp_time(samp_time), .conv_div(conv_div), .sh_sample(sh_sample),
  .ana_pd(ana_pd), .conv_busy(conv_busy), .dac_code0(dac_code0), .bwd_pre(bwd_pre),
  .mux_test_on(mux_test_on), .dig_in(dig_in), .dig_in_dis(dig_in_dis),
  .ext_mux_sel(ext_mux_sel), .res_evt(res_evt));

// ==== test/adc_request_sequencer_test.sv ====
/*
  self-checking bench: sequences of queue, trigger, insert and read calls.
  assumes: the analog model answers the trial codes; conv_div 3, samp 1.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module adc_request_sequencer_test;
  logic core_clk, rst_n, par_trig_en, sw_par_trig, q_wr_valid, q_trig_en, sw_q_trig;
  logic ins_req, sync_en, res8, emux_en, mux_test, rd_strobe, rd_conv, samp_q;
  logic q_wr_ready, ins_busy, rd_valid, conv_busy;
  logic [3:0] trig_ext, trig_int, amux0_sel;
  logic [23:0] par_mask, bwd_en, par_pend;
  logic [2:0] par_trig_sel, par_rsel, q_wr_rsel, q_trig_sel, ins_rsel, sync_chan1;
  logic [2:0] emux_last, rd_idx, amux1_sel, ext_mux_sel;
  logic [1:0] par_prio, q_prio, ins_prio, cmp_in, sh_sample, ana_pd, bwd_pre;
  logic [1:0] mux_test_on, res_evt;
  logic [4:0] q_wr_chan, ins_chan, emux_chan;
  logic [7:0] samp_time;
  logic [5:0] conv_div;
  logic [19:0] pin_in, dig_in_dis, dig_in;
  logic [15:0] wfr_en, chain_en, acc_en, lim_en, irq_sel;
  logic [9:0] lim_lo, lim_hi, dac_code0, dac_code1;
  logic [12:0] rd_data;
  logic [4:0] qc[$], ord[$], ex[$];
  logic [2:0] qr[$];
  int failures, n_checks, busy_n, evt_n, bwd_n, t10;
  adc_request_sequencer #(.QD(4)) adc_request_sequencer_inst (.*);
  ars_ana_model ars_ana_model_inst (.*);
  // ****************************************
  // clock, monitors and tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    samp_q <= sh_sample[0];
    if (sh_sample[0] && !samp_q) ord.push_back({1'b0, amux0_sel});
    if (!ana_pd[0]) busy_n <= busy_n + 1;
    if (res_evt[0]) evt_n <= evt_n + 1;
    if (bwd_pre[0] && mux_test_on[0]) bwd_n <= bwd_n + 1;
  end
  function automatic logic [12:0] v0(input logic [4:0] ch);
    v0 = 13'(ch) * 13'h0028 + 13'h0011;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_idle();
    int k, q;
    k = 0;
    q = 0;
    while (q < 12 && k < 3000) begin
      tick(1);
      k++;
      q = conv_busy ? 0 : q + 1;
    end
    if (k >= 3000) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic run_q();
    q_wr_valid = 1'b1;
    foreach (qc[k]) begin
      q_wr_chan = qc[k];
      q_wr_rsel = qr[k];
      tick(1);
    end
    q_wr_valid = 1'b0;
    ord.delete();
    pulse(sw_q_trig);
    wait_idle();
  endtask
  task automatic chk_rd(input logic c, input logic [2:0] i, input logic ev,
                        input logic [12:0] ed);
    rd_conv = c;
    rd_idx = i;
    pulse(rd_strobe);
    tick(1);
    `CHK(rd_valid, ev);
    if (ev) `CHK(rd_data, ed);
  endtask
  task automatic chk_ord();
    `CHK(ord.size(), ex.size());
    foreach (ex[k]) if (k < ord.size()) `CHK(ord[k], ex[k]);
  endtask
  task automatic done_t(input string s);
    $display("test %s done, mismatches so far %0d", s, failures);
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {trig_ext, trig_int, par_mask, bwd_en, par_trig_en, sw_par_trig, q_wr_valid} = '0;
    {q_trig_en, sw_q_trig, ins_req, sync_en, res8, emux_en, mux_test, rd_strobe} = '0;
    {rd_conv, par_trig_sel, par_rsel, q_wr_rsel, q_trig_sel, ins_rsel, sync_chan1} = '0;
    {emux_last, rd_idx, par_prio, q_prio, ins_prio, q_wr_chan, ins_chan, emux_chan} = '0;
    {pin_in, dig_in_dis, wfr_en, chain_en, acc_en, lim_en, irq_sel, lim_lo, samp_q} = '0;
    {failures, n_checks, busy_n, evt_n, bwd_n} = '0;
    samp_time = 8'h01;
    conv_div = 6'h03;
    lim_hi = 10'h3FF;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(1);
    `CHK(ana_pd, 2'h3);
    `CHK(ext_mux_sel, 3'h0);
    qc = '{5'h05, 5'h02, 5'h09, 5'h0C};
    qr = '{3'h0, 3'h1, 3'h2, 3'h3};
    ex = qc;
    run_q();
    chk_ord();
    foreach (qc[k]) chk_rd(1'b0, qr[k], 1'b1, v0(qc[k]));
    chk_rd(1'b0, 3'h0, 1'b0, 13'h0000);
    done_t("queue");
    par_mask = 24'h00108A;
    par_rsel = 3'h5;
    par_prio = 2'h1;
    {ins_chan, ins_rsel, ins_prio} = {5'h0E, 3'h6, 2'h2};
    ord.delete();
    pulse(sw_par_trig);
    `CHK(par_pend, 24'h00108A);
    tick(8);
    pulse(ins_req);
    `CHK(ins_busy, 1'b1);
    wait_idle();
    ex = '{5'h01, 5'h0E, 5'h03, 5'h07, 5'h0C};
    chk_ord();
    chk_rd(1'b0, 3'h6, 1'b1, v0(5'h0E));
    chk_rd(1'b0, 3'h5, 1'b1, v0(5'h0C));
    `CHK(par_pend, 24'h000000);
    done_t("insert");
    par_mask = 24'h000004;
    par_rsel = 3'h0;
    for (int p = 0; p < 2; p++) begin
      {q_prio, par_prio} = p ? {2'h0, 2'h2} : {2'h3, 2'h1};
      {q_wr_chan, q_wr_rsel} = {5'h08, 3'h0};
      q_wr_valid = 1'b1;
      tick(1);
      q_wr_valid = 1'b0;
      ord.delete();
      {sw_q_trig, sw_par_trig} = 2'h3;
      tick(1);
      {sw_q_trig, sw_par_trig} = 2'h0;
      wait_idle();
      if (p) ex = '{5'h02, 5'h08};
      else ex = '{5'h08, 5'h02};
      chk_ord();
    end
    done_t("priority");
    chk_rd(1'b0, 3'h0, 1'b1, v0(5'h08));
    wfr_en = 16'h0001;
    par_mask = 24'h000050;
    pulse(sw_par_trig);
    wait_idle();
    `CHK(par_pend, 24'h000040);
    chk_rd(1'b0, 3'h0, 1'b1, v0(5'h04));
    wait_idle();
    chk_rd(1'b0, 3'h0, 1'b1, v0(5'h06));
    `CHK(par_pend, 24'h000000);
    wfr_en = 16'h0000;
    done_t("wait for read");
    {lim_en, acc_en, lim_lo, lim_hi} = {16'h0004, 16'h0008, 10'h064, 10'h1F4};
    qc = '{5'h0D, 5'h05};
    qr = '{3'h2, 3'h2};
    run_q();
    chk_rd(1'b0, 3'h2, 1'b1, v0(5'h0D));
    qc = '{5'h03, 5'h03, 5'h03, 5'h03};
    qr = '{3'h3, 3'h3, 3'h3, 3'h3};
    run_q();
    chk_rd(1'b0, 3'h3, 1'b1, v0(5'h03) << 2);
    done_t("reduction");
    chain_en = 16'h00FE;
    qc = '{5'h01, 5'h09, 5'h0F};
    qr = '{3'h7, 3'h7, 3'h7};
    run_q();
    foreach (qc[k]) chk_rd(1'b0, 3'h0, 1'b1, v0(qc[k]));
    chk_rd(1'b0, 3'h0, 1'b0, 13'h0000);
    chain_en = 16'h0000;
    {sync_en, sync_chan1} = {1'b1, 3'h3};
    qc = '{5'h00};
    qr = '{3'h4};
    run_q();
    chk_rd(1'b0, 3'h4, 1'b1, v0(5'h00));
    chk_rd(1'b1, 3'h4, 1'b1, 13'h0316);
    sync_en = 1'b0;
    {emux_en, emux_chan, emux_last} = {1'b1, 5'h06, 3'h2};
    qc = '{5'h06, 5'h06, 5'h06, 5'h06};
    qr = '{3'h0, 3'h1, 3'h2, 3'h3};
    run_q();
    `CHK(ext_mux_sel, 3'h1);
    emux_en = 1'b0;
    qc = '{5'h02};
    qr = '{3'h0};
    busy_n = 0;
    run_q();
    t10 = busy_n;
    res8 = 1'b1;
    busy_n = 0;
    run_q();
    `CHK(t10 - busy_n, 8);
    chk_rd(1'b0, 3'h0, 1'b1, v0(5'h02) >> 2);
    res8 = 1'b0;
    done_t("chain sync emux width");
    {par_trig_en, par_mask, par_rsel, irq_sel} = {1'b1, 24'h000001, 3'h1, 16'h0002};
    {bwd_en, mux_test, evt_n, bwd_n} = {24'h000001, 1'b1, 64'h0};
    for (int s = 0; s < 8; s++) begin
      par_trig_sel = 3'(s);
      tick(1);
      if (s < 4) trig_ext[s] = 1'b1;
      else trig_int[s - 4] = 1'b1;
      tick(4 - s / 4 * 3);
      {trig_ext, trig_int} = 8'h00;
      wait_idle();
      chk_rd(1'b0, 3'h1, 1'b1, v0(5'h00));
    end
    `CHK(evt_n, 8);
    `CHK(bwd_n != 0, 1'b1);
    par_trig_en = 1'b0;
    {pin_in, dig_in_dis} = {20'hA5C3F, 20'h0F00F};
    tick(5);
    `CHK(dig_in, 20'hA5C3F & ~20'h0F00F);
    done_t("triggers and pins");
    wrap_up();
  end
endmodule
